/* File: pkg/usart_pkg.sv */
// Shared types and constants for the serial channel and its DMA channels.
// Assumes one 125 MHz clock and a synchronous active-high reset.
package usart_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_MODE   = 8'h04;
  localparam logic [7:0] OFS_STAT   = 8'h08;
  localparam logic [7:0] OFS_RXDATA = 8'h0C;
  localparam logic [7:0] OFS_TXDATA = 8'h10;
  localparam logic [7:0] OFS_BAUD   = 8'h14;
  localparam logic [7:0] OFS_TMO    = 8'h18;
  localparam logic [7:0] OFS_GUARD  = 8'h1C;
  localparam logic [3:0] PAGE_RXDMA = 4'h2;
  localparam logic [3:0] PAGE_TXDMA = 4'h3;

  // ----------------------------------------
  // Field encodings and layouts
  // ----------------------------------------
  typedef enum logic [2:0] {
    MD_NORMAL = 3'h0, MD_RS485 = 3'h1, MD_HANDSHAKE = 3'h2,
    MD_ISO_T0 = 3'h4, MD_ISO_T1 = 3'h6, MD_IRDA = 3'h7
  } mode_e;
  typedef enum logic [2:0] {
    PAR_EVEN = 3'h0, PAR_ODD = 3'h1, PAR_SPACE = 3'h2, PAR_MARK = 3'h3,
    PAR_NONE = 3'h4, PAR_MULTIDROP = 3'h6
  } par_e;
  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_START = 3'h1, S_DATA = 3'h3, S_PAR = 3'h2, S_STOP = 3'h6, S_GUARD = 3'h7
  } ser_e;
  typedef struct packed {
    logic [2:0] max_iter;
    logic       two_stop;
    par_e       par;
    logic [1:0] char_len;
    mode_e      mode;
  } mode_reg_s;
  typedef struct packed {
    logic tx_dma_en;
    logic rx_dma_en;
    logic tx_addr;
    logic tx_en;
    logic rx_en;
  } ctrl_reg_s;
  typedef struct packed {
    logic rx_addr;
    logic cts;
    logic cts_chg;
    logic rx_brk;
    logic nack;
    logic rx_buf_full;
    logic tx_buf_empty;
    logic iter;
    logic tx_empty;
    logic timeout;
    logic par_err;
    logic frm_err;
    logic ovr_err;
    logic end_tx;
    logic end_rx;
    logic tx_rdy;
    logic rx_rdy;
  } stat_s;

  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam ctrl_reg_s   CTRL_RST  = '0;
  localparam mode_reg_s   MODE_RST  = '{3'h3, 1'b0, PAR_NONE, 2'h3, MD_NORMAL};
  localparam logic [15:0] BAUD_RST  = 16'h043D;
  localparam logic [7:0]  TMO_RST   = 8'h00;
  localparam logic [7:0]  GUARD_RST = 8'h00;
  localparam logic [2:0]  LEN_BASE  = 3'h4;
  localparam logic [19:0] IRDA_MUL  = 20'h00003;
  localparam int          IRDA_SHR  = 4;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic        we;
    logic        re;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } reg_bus_s;
  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [7:0]  wdata;
  } dma_req_s;
  typedef struct packed {
    logic       ack;
    logic [7:0] rdata;
  } dma_rsp_s;
  typedef struct packed {
    logic [31:0] ptr;
    logic [15:0] cnt;
    logic [31:0] nptr;
    logic [15:0] ncnt;
  } dma_desc_s;
  localparam logic [1:0] DSEL_PTR  = 2'h0;
  localparam logic [1:0] DSEL_CNT  = 2'h1;
  localparam logic [1:0] DSEL_NPTR = 2'h2;
  localparam logic [1:0] DSEL_NCNT = 2'h3;

endpackage

/* File: core/usart_dma_chan.sv */
// One unidirectional peripheral_dma_channel with current and next descriptor.
// Assumes a memory port that answers a request with a one-cycle ack.
`timescale 1ns/1ps
module usart_dma_chan
  import usart_pkg::*;
#(
  parameter logic TO_MEM = 1'b0
) (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  // Peripheral side
  input  wire logic       en_i,
  input  wire logic       trig_i,
  input  wire logic [7:0] data_i,
  output dma_desc_s       desc_o,
  output logic            done_o,
  output logic [7:0]      data_o,
  // Software writes
  input  wire logic       sw_we_i,
  input  wire logic [1:0] sw_sel_i,
  input  wire logic [31:0] sw_data_i,
  // Memory side
  input  dma_rsp_s        rsp_i,
  output dma_req_s        req_o
);

  typedef struct packed {
    dma_desc_s  d;
    dma_req_s   req;
    logic       pend;
    logic       done;
    logic [7:0] data;
  } chan_state_s;

  chan_state_s q, s;

  always_comb begin
    s      = q;
    s.done = 1'b0;
    if (sw_we_i) begin
      unique case (sw_sel_i)
        DSEL_PTR:  s.d.ptr  = sw_data_i;
        DSEL_CNT:  s.d.cnt  = sw_data_i[15:0];
        DSEL_NPTR: s.d.nptr = sw_data_i;
        DSEL_NCNT: s.d.ncnt = sw_data_i[15:0];
      endcase
    end
    if (q.done) begin
      s.pend = 1'b0;
    end
    // Done cycle blocks a new request: trigger has not yet fallen
    if (!q.pend && !q.done && en_i && trig_i && q.d.cnt != 16'h0000) begin
      s.pend      = 1'b1;
      s.req.req   = 1'b1;
      s.req.we    = TO_MEM;
      s.req.addr  = q.d.ptr;
      s.req.wdata = data_i;
    end
    if (q.req.req && rsp_i.ack) begin
      s.req.req = 1'b0;
      s.done    = 1'b1;
      s.data    = rsp_i.rdata;
      s.d.ptr   = q.d.ptr + 32'h00000001;
      s.d.cnt   = q.d.cnt - 16'h0001;
    end
    if (s.d.cnt == 16'h0000 && s.d.ncnt != 16'h0000 && !s.pend) begin
      s.d.ptr  = s.d.nptr;
      s.d.cnt  = s.d.ncnt;
      s.d.nptr = 32'h00000000;
      s.d.ncnt = 16'h0000;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= s;
    end
  end

  assign desc_o = q.d;
  assign done_o = q.done;
  assign data_o = q.data;
  assign req_o  = q.req;

endmodule // usart_dma_chan

/* File: core/usart_core.sv */
// Serial channel: receiver, transmitter, mode logic and register port.
// Assumes pins synchronous to clock_i and two DMA memory ports.
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ps
module usart_core
  import usart_pkg::*;
(
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic rst_i,
  // Register port
  input  reg_bus_s    bus_i,
  output logic [31:0] rdata_o,
  // Serial pins
  input  wire logic rxd_i,
  input  wire logic cts_i,
  output logic      txd_o,
  output logic      rts_o,
  // DMA memory ports
  output dma_req_s  rx_req_o,
  input  dma_rsp_s  rx_rsp_i,
  output dma_req_s  tx_req_o,
  input  dma_rsp_s  tx_rsp_i
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    ctrl_reg_s   ctrl;
    mode_reg_s   mode;
    logic [15:0] baud;
    logic [7:0]  tmo;
    logic [7:0]  guard;
    logic [31:0] rdata;
    ser_e        rx_st;
    logic [15:0] rx_cnt;
    logic [2:0]  rx_bit;
    logic [7:0]  rx_sh;
    logic        rx_par;
    logic [7:0]  rhr;
    logic        rhr_addr;
    logic        rx_rdy;
    logic [15:0] ir_hold;
    logic [15:0] nack_cnt;
    logic [15:0] tmo_div;
    logic [7:0]  tmo_cnt;
    logic        tmo_arm;
    ser_e        tx_st;
    logic [15:0] tx_cnt;
    logic [2:0]  tx_bit;
    logic [7:0]  tx_sh;
    logic        tx_addr;
    logic        tx_stop2;
    logic        resend;
    logic [2:0]  iter_cnt;
    logic [7:0]  grd_cnt;
    logic [7:0]  thr;
    logic        thr_full;
    logic        ovr, frm, perr, tmo_flag, iter, nack, brk, cts_chg, cts;
    logic        txd;
    logic        rts;
  } core_state_s;

  core_state_s q, s;
  dma_desc_s   rx_desc, tx_desc;
  logic        rx_done, tx_done;
  logic [7:0]  tx_dma_data;
  logic        rx_dma_we, tx_dma_we;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic par_bit(logic [7:0] d, logic [1:0] len, par_e p, logic adr);
    logic [7:0] m;
    m = 8'hFF >> (2'h3 - len);
    unique case (p)
      PAR_EVEN:      par_bit = ^(d & m);
      PAR_ODD:       par_bit = ~^(d & m);
      PAR_SPACE:     par_bit = 1'b0;
      PAR_MARK:      par_bit = 1'b1;
      PAR_MULTIDROP: par_bit = adr;
      default:       par_bit = 1'b0;
    endcase
  endfunction

  function automatic logic [2:0] last_bit(logic [1:0] len);
    last_bit = {1'b0, len} + LEN_BASE;
  endfunction

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  logic        is_485, is_hs, is_t0, is_iso, is_ir, par_on, rx_tick, tx_tick, line, tx_go;
  logic [15:0] ir_w;
  stat_s       st;

  assign is_485 = q.mode.mode == MD_RS485;
  assign is_hs  = q.mode.mode == MD_HANDSHAKE;
  assign is_t0  = q.mode.mode == MD_ISO_T0;
  assign is_iso = is_t0 || q.mode.mode == MD_ISO_T1;
  assign is_ir  = q.mode.mode == MD_IRDA;
  assign par_on = q.mode.par != PAR_NONE;
  assign rx_tick = q.rx_cnt == 16'h0000;
  assign tx_tick = q.tx_cnt == 16'h0000;
  assign ir_w    = 16'(({4'h0, q.baud} * IRDA_MUL) >> IRDA_SHR);
  // Infrared: receiver line reads low while the transmitter is not idle
  assign line = is_ir ? (q.ir_hold == 16'h0000 && q.tx_st == S_IDLE) : rxd_i;
  assign tx_go = q.thr_full && q.ctrl.tx_en && !(is_hs && cts_i);

  always_comb begin
    st              = '0;
    st.rx_rdy       = q.rx_rdy;
    st.tx_rdy       = !q.thr_full;
    st.end_rx       = rx_desc.cnt == 16'h0000;
    st.end_tx       = tx_desc.cnt == 16'h0000;
    st.ovr_err      = q.ovr;
    st.frm_err      = q.frm;
    st.par_err      = q.perr;
    st.timeout      = q.tmo_flag;
    st.tx_empty     = !q.thr_full && q.tx_st == S_IDLE;
    st.iter         = q.iter;
    st.tx_buf_empty = st.end_tx && tx_desc.ncnt == 16'h0000;
    st.rx_buf_full  = st.end_rx && rx_desc.ncnt == 16'h0000;
    st.nack         = q.nack;
    st.rx_brk       = q.brk;
    st.cts_chg      = q.cts_chg;
    st.cts          = q.cts;
    st.rx_addr      = q.rhr_addr;
  end

  assign rx_dma_we = bus_i.we && bus_i.addr[7:4] == PAGE_RXDMA;
  assign tx_dma_we = bus_i.we && bus_i.addr[7:4] == PAGE_TXDMA;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s = q;
    // Register writes come first so hardware events below win over clears
    if (bus_i.we) begin
      unique case (bus_i.addr)
        OFS_CTRL:   s.ctrl  = ctrl_reg_s'(bus_i.wdata[$bits(ctrl_reg_s)-1:0]);
        OFS_MODE:   s.mode  = mode_reg_s'(bus_i.wdata[$bits(mode_reg_s)-1:0]);
        OFS_BAUD:   s.baud  = bus_i.wdata[15:0];
        OFS_TMO:    s.tmo   = bus_i.wdata[7:0];
        OFS_GUARD:  s.guard = bus_i.wdata[7:0];
        OFS_TXDATA: begin
          s.thr      = bus_i.wdata[7:0];
          s.thr_full = 1'b1;
        end
        OFS_STAT: begin
          stat_s c;
          c = stat_s'(bus_i.wdata[$bits(stat_s)-1:0]);
          s.ovr      = q.ovr && !c.ovr_err;
          s.frm      = q.frm && !c.frm_err;
          s.perr     = q.perr && !c.par_err;
          s.tmo_flag = q.tmo_flag && !c.timeout;
          s.iter     = q.iter && !c.iter;
          s.nack     = q.nack && !c.nack;
          s.brk      = q.brk && !c.rx_brk;
          s.cts_chg  = q.cts_chg && !c.cts_chg;
        end
        default: ;
      endcase
    end
    s.rdata = 32'h00000000;
    if (bus_i.re) begin
      unique case (bus_i.addr[7:4])
        PAGE_RXDMA, PAGE_TXDMA: begin
          dma_desc_s d;
          d = (bus_i.addr[7:4] == PAGE_RXDMA) ? rx_desc : tx_desc;
          unique case (bus_i.addr[3:2])
            DSEL_PTR:  s.rdata = d.ptr;
            DSEL_CNT:  s.rdata = {16'h0000, d.cnt};
            DSEL_NPTR: s.rdata = d.nptr;
            DSEL_NCNT: s.rdata = {16'h0000, d.ncnt};
          endcase
        end
        default: begin
          unique case (bus_i.addr)
            OFS_CTRL:   s.rdata = 32'(q.ctrl);
            OFS_MODE:   s.rdata = 32'(q.mode);
            OFS_STAT:   s.rdata = 32'(st);
            OFS_BAUD:   s.rdata = {16'h0000, q.baud};
            OFS_TMO:    s.rdata = {24'h000000, q.tmo};
            OFS_GUARD:  s.rdata = {24'h000000, q.guard};
            OFS_RXDATA: begin
              s.rdata  = {24'h000000, q.rhr};
              s.rx_rdy = 1'b0;
            end
            default: s.rdata = 32'h00000000;
          endcase
        end
      endcase
    end
    if (rx_done) begin
      s.rx_rdy = 1'b0;
    end

    // CTS change
    s.cts = cts_i;
    if (cts_i != q.cts) begin
      s.cts_chg = 1'b1;
    end

    // Infrared demodulator stretches each pulse to one bit
    if (!rxd_i) begin
      s.ir_hold = q.baud;
    end else if (q.ir_hold != 16'h0000) begin
      s.ir_hold = q.ir_hold - 16'h0001;
    end
    if (q.nack_cnt != 16'h0000) begin
      s.nack_cnt = q.nack_cnt - 16'h0001;
    end

    // Receiver
    if (q.rx_st != S_IDLE) begin
      s.rx_cnt = rx_tick ? q.baud - 16'h0001 : q.rx_cnt - 16'h0001;
    end
    unique case (q.rx_st)
      S_IDLE: begin
        if (q.ctrl.rx_en && !line) begin
          s.rx_st  = S_START;
          s.rx_cnt = q.baud >> 1;
          s.rx_sh  = 8'h00;
          s.rx_bit = 3'h0;
          s.rx_par = 1'b0;
        end
      end
      S_START: begin
        if (rx_tick) begin
          s.rx_st = line ? S_IDLE : S_DATA;
        end
      end
      S_DATA: begin
        if (rx_tick) begin
          s.rx_sh[q.rx_bit] = line;
          s.rx_bit          = q.rx_bit + 3'h1;
          if (q.rx_bit == last_bit(q.mode.char_len)) begin
            s.rx_st = par_on ? S_PAR : S_STOP;
          end
        end
      end
      S_PAR: begin
        if (rx_tick) begin
          s.rx_par = line;
          s.rx_st  = S_STOP;
        end
      end
      S_STOP: begin
        if (rx_tick) begin
          s.rx_st   = line ? S_IDLE : S_GUARD;
          s.tmo_arm = 1'b1;
          s.tmo_cnt = 8'h00;
          s.tmo_div = q.baud;
          if (!line && q.rx_sh == 8'h00 && !q.rx_par) begin
            s.brk = 1'b1;
          end else begin
            logic pe;
            pe = par_on && q.mode.par != PAR_MULTIDROP
                 && q.rx_par != par_bit(q.rx_sh, q.mode.char_len, q.mode.par, 1'b0);
            if (!line) begin
              s.frm = 1'b1;
            end
            if (pe) begin
              s.perr = 1'b1;
            end
            if (pe && is_t0) begin
              s.nack_cnt = q.baud; // Card repeats the character; keep nothing
            end else if (s.rx_rdy) begin
              s.ovr = 1'b1;
            end else begin
              s.rhr      = q.rx_sh;
              s.rhr_addr = q.mode.par == PAR_MULTIDROP && q.rx_par;
              s.rx_rdy   = 1'b1;
            end
          end
        end
      end
      S_GUARD: begin
        if (line) begin
          s.rx_st = S_IDLE;
        end
      end
      default: s.rx_st = S_IDLE;
    endcase
    if (!q.ctrl.rx_en) begin
      s.rx_st = S_IDLE;
    end

    // Idle time-out, counted in bit periods
    if (q.tmo_arm && q.tmo != 8'h00 && q.rx_st == S_IDLE) begin
      s.tmo_div = q.tmo_div - 16'h0001;
      if (q.tmo_div == 16'h0000) begin
        s.tmo_div = q.baud;
        s.tmo_cnt = q.tmo_cnt + 8'h01;
        if (q.tmo_cnt + 8'h01 == q.tmo) begin
          s.tmo_flag = 1'b1;
          s.tmo_arm  = 1'b0;
        end
      end
    end

    // Transmitter
    if (q.tx_st != S_IDLE) begin
      s.tx_cnt = tx_tick ? q.baud - 16'h0001 : q.tx_cnt - 16'h0001;
    end
    unique case (q.tx_st)
      S_IDLE: begin
        if (tx_go) begin
          s.tx_st    = S_START;
          s.tx_cnt   = q.baud - 16'h0001;
          s.tx_sh    = q.thr;
          s.tx_addr  = q.ctrl.tx_addr;
          s.thr_full = 1'b0;
          s.iter_cnt = 3'h0;
        end
      end
      S_START: begin
        if (tx_tick) begin
          s.tx_st  = S_DATA;
          s.tx_bit = 3'h0;
        end
      end
      S_DATA: begin
        if (tx_tick) begin
          s.tx_bit = q.tx_bit + 3'h1;
          if (q.tx_bit == last_bit(q.mode.char_len)) begin
            s.tx_st    = par_on ? S_PAR : S_STOP;
            s.tx_stop2 = 1'b0;
          end
        end
      end
      S_PAR: begin
        if (tx_tick) begin
          s.tx_st = S_STOP;
        end
      end
      S_STOP: begin
        if (tx_tick) begin
          if (!q.tx_stop2 && (q.mode.two_stop || is_iso)) begin
            s.tx_stop2 = 1'b1;
            if (is_t0 && !rxd_i) begin
              s.nack = 1'b1;
              if (q.iter_cnt == q.mode.max_iter) begin
                s.iter = 1'b1;
              end else begin
                s.resend = 1'b1;
              end
            end
          end else begin
            s.tx_st   = S_GUARD;
            s.grd_cnt = 8'h00;
          end
        end
      end
      S_GUARD: begin
        if (tx_tick) begin
          s.grd_cnt = q.grd_cnt + 8'h01;
        end
        if (q.grd_cnt >= q.guard) begin
          s.tx_st = S_IDLE;
          if (q.resend) begin
            s.resend   = 1'b0;
            s.iter_cnt = q.iter_cnt + 3'h1;
            s.tx_st    = S_START;
            s.tx_cnt   = q.baud - 16'h0001;
          end
        end
      end
      default: s.tx_st = S_IDLE;
    endcase
    if (tx_done) begin
      s.thr      = tx_dma_data;
      s.thr_full = 1'b1;
    end

    // Pin drivers
    unique case (s.tx_st)
      S_START: s.txd = 1'b0;
      S_DATA:  s.txd = s.tx_sh[s.tx_bit];
      S_PAR:   s.txd = par_bit(s.tx_sh, q.mode.char_len, q.mode.par, s.tx_addr);
      default: s.txd = 1'b1;
    endcase
    if (is_ir) begin
      s.txd = !s.txd && s.tx_cnt >= q.baud - ir_w;
    end else if (s.nack_cnt != 16'h0000) begin
      s.txd = 1'b0;
    end
    // Guard time is after the last stop bit, so RTS drops there
    if (is_485) begin
      s.rts = s.thr_full || s.resend || (s.tx_st != S_IDLE && s.tx_st != S_GUARD);
    end else if (is_hs) begin
      s.rts = !q.ctrl.rx_en || st.rx_buf_full;
    end else begin
      s.rts = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      q       <= '0;
      q.ctrl  <= CTRL_RST;
      q.mode  <= MODE_RST;
      q.baud  <= BAUD_RST;
      q.tmo   <= TMO_RST;
      q.guard <= GUARD_RST;
      q.txd   <= 1'b1;
    end else begin
      q <= s;
    end
  end

  // ----------------------------------------
  // DMA channels
  // ----------------------------------------
  usart_dma_chan #(.TO_MEM(1'b1)) u_rx_dma (
    .clock_i   (clock_i),
    .rst_i     (rst_i),
    .en_i      (q.ctrl.rx_dma_en),
    .trig_i    (q.rx_rdy),
    .data_i    (q.rhr),
    .desc_o    (rx_desc),
    .done_o    (rx_done),
    .data_o    (),
    .sw_we_i   (rx_dma_we),
    .sw_sel_i  (bus_i.addr[3:2]),
    .sw_data_i (bus_i.wdata),
    .rsp_i     (rx_rsp_i),
    .req_o     (rx_req_o)
  );

  usart_dma_chan #(.TO_MEM(1'b0)) u_tx_dma (
    .clock_i   (clock_i),
    .rst_i     (rst_i),
    .en_i      (q.ctrl.tx_dma_en),
    .trig_i    (!q.thr_full),
    .data_i    (8'h00),
    .desc_o    (tx_desc),
    .done_o    (tx_done),
    .data_o    (tx_dma_data),
    .sw_we_i   (tx_dma_we),
    .sw_sel_i  (bus_i.addr[3:2]),
    .sw_data_i (bus_i.wdata),
    .rsp_i     (tx_rsp_i),
    .req_o     (tx_req_o)
  );

  assign rdata_o = q.rdata;
  assign txd_o   = q.txd;
  assign rts_o   = q.rts;

endmodule // usart_core

/* File: verification/usart_monitor.sv */
// Port checks for the serial core.
// Assumes binding to usart_core, one clock.
`timescale 1ns/1ps
module usart_monitor
  import usart_pkg::*;
(
  // Clock and reset
  input wire logic        clock_i,
  input wire logic        rst_i,
  // Register port
  input reg_bus_s         bus_i,
  input wire logic [31:0] rdata_o,
  // Pins and DMA
  input wire logic        rxd_i,
  input wire logic        cts_i,
  input wire logic        txd_o,
  input wire logic        rts_o,
  input dma_req_s         rx_req_o,
  input dma_rsp_s         rx_rsp_i,
  input dma_req_s         tx_req_o,
  input dma_rsp_s         tx_rsp_i
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // ----
  // Software view of mode and control enables
  // ----
  mode_e      md_q;
  logic [4:0] ce_q;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      md_q <= MD_NORMAL;
      ce_q <= '0;
    end else if (bus_i.we && bus_i.addr == OFS_MODE) begin
      md_q <= mode_e'(bus_i.wdata[2:0]);
    end else if (bus_i.we && bus_i.addr == OFS_CTRL) begin
      ce_q <= bus_i.wdata[4:0];
    end
  end
  a_rx_hold: assert property (rx_req_o.req && !rx_rsp_i.ack |=> rx_req_o.req && $stable(rx_req_o.addr))
    else $error("rx request dropped early");
  a_tx_hold: assert property (tx_req_o.req && !tx_rsp_i.ack |=> tx_req_o.req && $stable(tx_req_o.addr))
    else $error("tx request dropped early");
  a_rx_dir: assert property (rx_req_o.req |-> rx_req_o.we)
    else $error("rx request not a write");
  a_rx_gap: assert property (rx_rsp_i.ack |=> !rx_req_o.req)
    else $error("rx request right after ack");
  a_tx_drop: assert property ($fell(tx_req_o.req) |-> $past(tx_rsp_i.ack))
    else $error("tx request fell without ack");
  a_rs485_rts: assert property (md_q == MD_RS485 && !txd_o |-> rts_o)
    else $error("rts low while sending");
  a_hs_rts: assert property ((md_q == MD_HANDSHAKE && !ce_q[0]) [*3] |-> rts_o)
    else $error("rts low with receiver off");
  a_plain_rts: assert property ((md_q == MD_NORMAL) [*3] |-> !rts_o)
    else $error("rts high in normal mode");
endmodule // usart_monitor

bind usart_core usart_monitor mon (
  .clock_i(clock_i), .rst_i(rst_i), .bus_i(bus_i), .rdata_o(rdata_o), .rxd_i(rxd_i), .cts_i(cts_i),
  .txd_o(txd_o), .rts_o(rts_o), .rx_req_o(rx_req_o), .rx_rsp_i(rx_rsp_i), .tx_req_o(tx_req_o),
  .tx_rsp_i(tx_rsp_i)
);

/* File: verification/usart_remote.sv */
// Remote serial device: 8N1 sender and receiver.
// Assumes the core runs BIT clocks per bit.
`timescale 1ns/1ps
module usart_remote #(
  parameter int BIT = 16
) (
  // Line side
  input  wire logic  clock_i,
  input  wire logic  txd_i,
  output logic       rxd_o,
  output logic [7:0] got_o,
  output logic       got_v_o
);
  // ----
  // Receiver, mid-bit sampling
  // ----
  initial begin
    rxd_o = 1'b1;
    got_o = '0;
    got_v_o = 1'b0;
    forever begin
      @(negedge txd_i);
      repeat (BIT / 2) @(posedge clock_i);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge clock_i);
        got_o[i] = txd_i;
      end
      repeat (BIT) @(posedge clock_i);
      got_v_o <= txd_i;
      @(posedge clock_i);
      got_v_o <= 1'b0;
    end
  end
  // Trailing idle bit keeps frames apart without a second drive in one step
  task automatic send(input logic [7:0] b, input logic stp);
    logic [10:0] f;
    f = {1'b1, stp, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd_o <= f[i];
      repeat (BIT) @(posedge clock_i);
    end
  endtask
endmodule // usart_remote

/* File: verification/tb.sv */
// Self-checking bench for the serial core.
// Assumes the remote model and an ack-per-request memory.
`timescale 1ns/1ps
module tb;
  import usart_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  reg_bus_s    bus = '0;
  logic [31:0] rdata;
  logic        rxd, txd, rts, got_v;
  logic        cts = 1'b0;
  logic [7:0]  got;
  logic [7:0]  wb = '0;
  dma_req_s    rxq, txq;
  dma_rsp_s    rxs = '0;
  dma_rsp_s    txs = '0;
  int          fails = 0;
  int          n_checks = 0;
  always #4 clk = ~clk;
  usart_core DUT (
    .clock_i(clk), .rst_i(rst), .bus_i(bus), .rdata_o(rdata), .rxd_i(rxd), .cts_i(cts),
    .txd_o(txd), .rts_o(rts), .rx_req_o(rxq), .rx_rsp_i(rxs), .tx_req_o(txq), .tx_rsp_i(txs)
  );
  usart_remote #(.BIT(16)) rem (
    .clock_i(clk), .txd_i(txd), .rxd_o(rxd), .got_o(got), .got_v_o(got_v)
  );
  // ----
  // Memory: one-cycle ack, data from address
  // ----
  always @(posedge clk) begin
    rxs.ack <= rxq.req & ~rxs.ack;
    txs.ack <= txq.req & ~txs.ack;
    txs.rdata <= txq.addr[15:8] ^ 8'h5A;
    if (rxs.ack)
      wb <= rxq.wdata;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    bus.we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    bus <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clk);
    bus.re <= 1'b0;
    #1 v = rdata;
  endtask
  // Bounded wait for one character at the remote end
  task automatic take(output logic [31:0] v);
    v = 'x;
    for (int i = 0; i < 400; i++) begin
      @(posedge clk);
      if (got_v === 1'b1) begin
        v = {24'h0, got};
        break;
      end
    end
  endtask
  task automatic t_regs;
    logic [31:0] v;
    rd(OFS_MODE, v);
    chk(v, 32'h698);
    rd(8'hFC, v);
    chk(v, 32'h0);
    wr(OFS_BAUD, 32'h10);
    rd(OFS_BAUD, v);
    chk(v, 32'h10);
    wr(OFS_CTRL, 32'h3);
    wr(OFS_TXDATA, 32'hA5);
    take(v);
    chk(v, 32'hA5);
  endtask
  task automatic t_rx;
    logic [31:0] v;
    wr(OFS_TMO, 32'h2);
    rem.send(8'h3C, 1'b1);
    rd(OFS_RXDATA, v);
    chk(v, 32'h3C);
    rem.send(8'h11, 1'b1);
    rem.send(8'h22, 1'b1);
    rd(OFS_STAT, v);
    chk(v & 32'h10, 32'h10);
    rd(OFS_RXDATA, v);
    chk(v, 32'h11);
    wr(OFS_STAT, 32'hFFFF);
    rem.send(8'h55, 1'b0);
    rd(OFS_STAT, v);
    chk(v & 32'h2020, 32'h20);
    rem.send(8'h00, 1'b0);
    rd(OFS_STAT, v);
    chk(v & 32'h2080, 32'h2000);
    rd(OFS_RXDATA, v);
    chk(v, 32'h55);
    repeat (40) @(posedge clk);
    rd(OFS_STAT, v);
    chk(v & 32'h80, 32'h80);
  endtask
  task automatic t_rs485;
    logic [31:0] v;
    wr(OFS_MODE, 32'h699);
    wr(OFS_GUARD, 32'h1);
    wr(OFS_TXDATA, 32'h5A);
    repeat (8) @(posedge clk);
    chk({31'h0, rts}, 32'h1);
    take(v);
    chk(v, 32'h5A);
    repeat (8) @(posedge clk);
    rd(OFS_STAT, v);
    chk(v & 32'h100, 32'h0);
    repeat (24) @(posedge clk);
    chk({31'h0, rts}, 32'h0);
    rd(OFS_STAT, v);
    chk(v & 32'h100, 32'h100);
  endtask
  task automatic t_hs;
    logic [31:0] v;
    wr(OFS_MODE, 32'h69A);
    wr(OFS_CTRL, 32'h0);
    repeat (4) @(posedge clk);
    chk({31'h0, rts}, 32'h1);
    wr(8'h20, 32'h80);
    wr(8'h24, 32'h1);
    wr(OFS_CTRL, 32'hB);
    repeat (4) @(posedge clk);
    chk({31'h0, rts}, 32'h0);
    cts <= 1'b1;
    wr(OFS_TXDATA, 32'h81);
    repeat (64) @(posedge clk);
    chk({31'h0, txd}, 32'h1);
    cts <= 1'b0;
    take(v);
    chk(v, 32'h81);
    rem.send(8'h96, 1'b1);
    repeat (8) @(posedge clk);
    chk({24'h0, wb}, 32'h96);
    rd(OFS_STAT, v);
    chk(v & 32'h4804, 32'h4804);
    chk({31'h0, rts}, 32'h1);
  endtask
  task automatic t_dma;
    logic [31:0] v;
    wr(OFS_MODE, 32'h698);
    wr(8'h30, 32'h100);
    wr(8'h34, 32'h1);
    wr(8'h38, 32'h200);
    wr(8'h3C, 32'h1);
    wr(OFS_CTRL, 32'h12);
    take(v);
    chk(v, 32'h5B);
    take(v);
    chk(v, 32'h58);
    rd(8'h3C, v);
    chk(v, 32'h0);
    rd(8'h38, v);
    chk(v, 32'h0);
    rd(OFS_STAT, v);
    chk(v & 32'h408, 32'h408);
  endtask
  task automatic results;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    results();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_rx();
    t_rs485();
    t_hs();
    t_dma();
    results();
  end
endmodule // tb
